//--- wdog_tick_defs.svh
// offsets, field positions, reset values and counts of the watchdog and tick block
// assumes 8-bit registers on a plain strobe port, one byte per address
`ifndef WDOG_TICK_DEFS_SVH
`define WDOG_TICK_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_WDOG_CONFIG 8'h00
`define OFS_WDOG_SERVICE 8'h01
`define OFS_TICK_PERIOD 8'h02
`define OFS_CLK_CTRL 8'h03
`define OFS_OSC_FILTER 8'h04
`define OFS_IRQ_MASK 8'h05
`define OFS_IRQ_STATUS 8'h06
`define OFS_STATUS 8'h07

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_WINDOWED_EN 7
`define BIT_WDOG_CLK_SEL 6
`define BIT_PS_WDOG_RUN 5
`define BIT_TICK_CLK_SEL 0
`define BIT_PS_TICK_RUN 1
`define BIT_PSEUDO_STOP 2
`define BIT_EXT_OSC_EN 3
`define BIT_FLAG_TICK 0
`define BIT_FLAG_PLL 1
`define BIT_FLAG_OSC 2
`define BIT_FLAG_LV 3

// ----------------------------------------------------------------
// service bytes, reset values, counts
// ----------------------------------------------------------------
`define SVC_FIRST 8'h55
`define SVC_SECOND 8'hAA
`define RST_WDOG_CONFIG 8'h00
`define RST_TICK_PERIOD 8'h00
`define RST_CLK_CTRL 8'h00
`define RST_OSC_FILTER 5'h00
`define RST_IRQ_MASK 4'h0
`define WDOG_EXP_BASE 8
`define TICK_UNIT_SHIFT 4

`endif

//--- wdog_tick_pkg.sv
// types shared by the watchdog and tick block
// assumes wdog_tick_defs.svh for all numbers
package wdog_tick_pkg;

  // service sequence position
  typedef enum logic {svc_idle, svc_armed} svc_state_t;

  typedef logic [23:0] count_t;

endpackage

//--- period_timer.sv
// free running period counter that advances on source ticks
// assumes adv is a one-cycle pulse in the ref_clk domain
`timescale 1ns/1ps
module period_timer
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic adv,
  input wire logic restart,
  input wire wdog_tick_pkg::count_t limit,
  output wdog_tick_pkg::count_t count,
  output logic expire
);

  // last count of a period reached on an advancing tick
  wire logic at_end;
  assign at_end = (limit != 24'h000000) && (count >= limit - 24'h000001);
  assign expire = adv && at_end && !restart;

  // count and wrap, restart wins
  always_ff @(posedge ref_clk)
  begin
    if (!rstn || restart)
      count <= 24'h000000;
    else if (adv && limit != 24'h000000)
      count <= at_end ? 24'h000000 : count + 24'h000001;
  end

endmodule

//--- sticky_flag.sv
// sticky status flag, set wins over clear
// assumes set and clr are synchronous to ref_clk
`timescale 1ns/1ps
module sticky_flag
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic set,
  input wire logic clr,
  output logic flag
);

  // hold until cleared, a same-cycle set survives the clear
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      flag <= 1'b0;
    else if (set)
      flag <= 1'b1;
    else if (clr)
      flag <= 1'b0;
  end

endmodule

//--- wdog_tick_status.sv
// watchdog, periodic tick and clock/voltage status flags with one interrupt
// assumes source clocks arrive as one-cycle tick pulses synchronous to ref_clk
//
// Contract
// (R01) watchdog counts internal or oscillator ticks per wdog_clk_sel
// (R02) in stop mode watchdog runs only under pseudo stop, oscillator source, run bit
// (R03) three-bit period field gives seven periods, zero turns watchdog off
// (R04) writing 0x55 then 0xAA restarts the watchdog period
// (R05) expiry without service raises watchdog reset
// (R06) any other service byte raises watchdog reset at once
// (R07) windowed mode accepts service only in last quarter, earlier resets
// (R08) tick counter source select and stop-mode run like the watchdog
// (R09) tick end sets tick flag, next period starts, interrupt if enabled
// (R10) any write to tick period register restarts the tick period
// (R11) pll settled toggle sets its flag, writing one clears it
// (R12) pll flag gives no interrupt while its enable is zero
// (R13) qualified status zero with oscillator off, filter zero follows pll
// (R14) qualified status change sets oscillator flag, interrupt when enabled
// (R15) losing pll settled status clears qualified status
// (R16) full performance mode low-voltage bit follows comparator, change sets flag
// (R17) first normal-mode config write locks window enable and period
// (R18) flags stay until cleared, interrupt is OR of enabled flags
`timescale 1ns/1ps
`include "wdog_tick_defs.svh"
module wdog_tick_status
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic internal_ref_clock,
  input wire logic ext_osc_clock,
  input wire logic stop_mode,
  input wire logic normal_mode,
  input wire logic full_performance_mode,
  input wire logic pll_settled,
  input wire logic osc_filter_ok,
  input wire logic supply_low,
  output logic wdog_reset,
  output logic irq
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------

  // watchdog period in source ticks, zero means off
  function automatic wdog_tick_pkg::count_t wdog_limit(input logic [2:0] sel);
    logic [4:0] shift;
    shift = 5'(`WDOG_EXP_BASE) + {1'b0, sel, 1'b0};
    wdog_limit = (sel == 3'h0) ? 24'h000000 : (24'h000001 << shift);
  endfunction

  // true while the count lies before the last quarter of the period
  function automatic logic before_window(input wdog_tick_pkg::count_t cnt,
                                         input wdog_tick_pkg::count_t lim);
    before_window = cnt < (lim - (lim >> 2));
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic windowed_wdog_en;
  logic wdog_clk_sel;
  logic pseudo_stop_wdog_run;
  logic [2:0] wdog_period_sel;
  logic wdog_locked;
  logic [7:0] tick_period;
  logic tick_clk_sel;
  logic pseudo_stop_tick_run;
  logic pseudo_stop_sel;
  logic ext_osc_enable;
  logic [4:0] osc_filter_setting;
  logic tick_irq_en;
  logic pll_settle_irq_en;
  logic osc_status_irq_en;
  logic low_voltage_irq_en;
  logic osc_qualified_status;
  logic low_voltage_status;
  logic pll_prev;
  wdog_tick_pkg::svc_state_t svc_state;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire logic wr_config;
  wire logic wr_service;
  wire logic wr_tick;
  wire logic wr_clk;
  wire logic wr_filter;
  wire logic wr_mask;
  wire logic wr_status;
  wire logic rd_status;
  assign wr_config = wr_stb && addr == `OFS_WDOG_CONFIG;
  assign wr_service = wr_stb && addr == `OFS_WDOG_SERVICE;
  assign wr_tick = wr_stb && addr == `OFS_TICK_PERIOD;
  assign wr_clk = wr_stb && addr == `OFS_CLK_CTRL;
  assign wr_filter = wr_stb && addr == `OFS_OSC_FILTER;
  assign wr_mask = wr_stb && addr == `OFS_IRQ_MASK;
  assign wr_status = wr_stb && addr == `OFS_IRQ_STATUS;
  assign rd_status = rd_stb && addr == `OFS_IRQ_STATUS;

  // ----------------------------------------------------------------
  // watchdog timing
  // ----------------------------------------------------------------
  wire logic wdog_src;
  wire logic wdog_run;
  wire logic wdog_adv;
  wire wdog_tick_pkg::count_t wdog_lim;
  wdog_tick_pkg::count_t wdog_count;
  logic wdog_expire;
  assign wdog_src = wdog_clk_sel ? ext_osc_clock : internal_ref_clock; // see R01
  assign wdog_run = !stop_mode
                    || (pseudo_stop_sel && wdog_clk_sel && pseudo_stop_wdog_run); // see R02
  assign wdog_adv = wdog_src && wdog_run;
  assign wdog_lim = wdog_limit(wdog_period_sel); // see R03

  // service sequence decode
  wire logic svc_is_first;
  wire logic svc_is_second;
  wire logic svc_bad;
  wire logic svc_early;
  wire logic svc_done;
  wire logic wdog_fire;
  assign svc_is_first = wr_service && wdata == `SVC_FIRST;
  assign svc_is_second = wr_service && wdata == `SVC_SECOND;
  assign svc_bad = wr_service && !svc_is_first && !svc_is_second; // see R06
  assign svc_early = wr_service && windowed_wdog_en && wdog_lim != 24'h000000
                     && before_window(wdog_count, wdog_lim); // see R07
  assign svc_done = svc_is_second && svc_state == wdog_tick_pkg::svc_armed
                    && !svc_early; // see R04
  assign wdog_fire = wdog_expire || svc_bad || svc_early; // see R05

  period_timer wdog_timer
  (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .adv(wdog_adv),
    .restart(svc_done || svc_bad || svc_early || wr_config), // expiry wraps on its own
    .limit(wdog_lim),
    .count(wdog_count),
    .expire(wdog_expire)
  );

  // service sequence state
  always_ff @(posedge ref_clk)
  begin
    if (!rstn || wdog_fire || svc_is_second)
      svc_state <= wdog_tick_pkg::svc_idle;
    else if (svc_is_first)
      svc_state <= wdog_tick_pkg::svc_armed;
  end

  // reset request pulse
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      wdog_reset <= 1'b0;
    else
      wdog_reset <= wdog_fire;
  end

  // watchdog configuration with write-once lock
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      {windowed_wdog_en, wdog_clk_sel, pseudo_stop_wdog_run, wdog_period_sel}
        <= 6'(`RST_WDOG_CONFIG);
      wdog_locked <= 1'b0;
    end
    else if (wr_config)
    begin
      wdog_clk_sel <= wdata[`BIT_WDOG_CLK_SEL];
      pseudo_stop_wdog_run <= wdata[`BIT_PS_WDOG_RUN];
      if (!wdog_locked) // see R17
      begin
        windowed_wdog_en <= wdata[`BIT_WINDOWED_EN];
        wdog_period_sel <= wdata[2:0];
      end
      if (normal_mode)
        wdog_locked <= 1'b1; // see R17
    end
  end

  // ----------------------------------------------------------------
  // periodic tick
  // ----------------------------------------------------------------
  wire logic tick_src;
  wire logic tick_run;
  wire wdog_tick_pkg::count_t tick_lim;
  wdog_tick_pkg::count_t tick_count;
  logic tick_expire;
  assign tick_src = tick_clk_sel ? ext_osc_clock : internal_ref_clock; // see R08
  assign tick_run = !stop_mode
                    || (pseudo_stop_sel && tick_clk_sel && pseudo_stop_tick_run); // see R08
  assign tick_lim = {12'h000, tick_period, 4'h0};

  period_timer tick_timer
  (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .adv(tick_src && tick_run),
    .restart(wr_tick), // see R10
    .limit(tick_lim),
    .count(tick_count),
    .expire(tick_expire) // see R09
  );

  // tick period and clock control
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      tick_period <= `RST_TICK_PERIOD;
      {ext_osc_enable, pseudo_stop_sel, pseudo_stop_tick_run, tick_clk_sel} <= 4'(`RST_CLK_CTRL);
      osc_filter_setting <= `RST_OSC_FILTER;
      {low_voltage_irq_en, osc_status_irq_en, pll_settle_irq_en, tick_irq_en} <= `RST_IRQ_MASK;
    end
    else
    begin
      if (wr_tick)
        tick_period <= wdata;
      if (wr_clk)
        {ext_osc_enable, pseudo_stop_sel, pseudo_stop_tick_run, tick_clk_sel} <= wdata[3:0];
      if (wr_filter)
        osc_filter_setting <= wdata[4:0];
      if (wr_mask)
        {low_voltage_irq_en, osc_status_irq_en, pll_settle_irq_en, tick_irq_en} <= wdata[3:0];
    end
  end

  // ----------------------------------------------------------------
  // clock and voltage status
  // ----------------------------------------------------------------
  wire logic next_osc_qualified;
  wire logic next_low_voltage;
  assign next_osc_qualified = ext_osc_enable && pll_settled
                              && (osc_filter_setting == 5'h00 || osc_filter_ok); // see R13 R15
  assign next_low_voltage = full_performance_mode ? supply_low : low_voltage_status; // see R16

  // status trackers
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      osc_qualified_status <= 1'b0;
      low_voltage_status <= 1'b0;
      pll_prev <= 1'b0;
    end
    else
    begin
      osc_qualified_status <= next_osc_qualified;
      low_voltage_status <= next_low_voltage;
      pll_prev <= pll_settled;
    end
  end

  // ----------------------------------------------------------------
  // flags and interrupt
  // ----------------------------------------------------------------
  logic [3:0] flags;
  wire logic [3:0] flag_set;
  wire logic [3:0] flag_clr;
  wire logic [3:0] irq_en;
  assign flag_set[`BIT_FLAG_TICK] = tick_expire; // see R09
  assign flag_set[`BIT_FLAG_PLL] = pll_settled != pll_prev; // see R11
  assign flag_set[`BIT_FLAG_OSC] = next_osc_qualified != osc_qualified_status; // see R14
  assign flag_set[`BIT_FLAG_LV] = next_low_voltage != low_voltage_status; // see R16
  assign flag_clr = {4{rd_status}} | ({4{wr_status}} & wdata[3:0]); // see R11
  assign irq_en = {low_voltage_irq_en, osc_status_irq_en, pll_settle_irq_en, tick_irq_en};

  sticky_flag flag_bit[3:0]
  (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .set(flag_set),
    .clr(flag_clr),
    .flag(flags) // see R18
  );

  // level interrupt from enabled flags
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      irq <= 1'b0;
    else
      irq <= |(flags & irq_en); // see R12 R18
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  wire logic [7:0] rd_mux;
  assign rd_mux =
    (addr == `OFS_WDOG_CONFIG) ? {windowed_wdog_en, wdog_clk_sel, pseudo_stop_wdog_run,
                                  2'h0, wdog_period_sel} :
    (addr == `OFS_TICK_PERIOD) ? tick_period :
    (addr == `OFS_CLK_CTRL) ? {4'h0, ext_osc_enable, pseudo_stop_sel,
                               pseudo_stop_tick_run, tick_clk_sel} :
    (addr == `OFS_OSC_FILTER) ? {3'h0, osc_filter_setting} :
    (addr == `OFS_IRQ_MASK) ? {4'h0, irq_en} :
    (addr == `OFS_IRQ_STATUS) ? {4'h0, flags} :
    (addr == `OFS_STATUS) ? {4'h0, wdog_locked, low_voltage_status,
                             osc_qualified_status, pll_settled} :
    8'h00;

  // registered read answer, zero outside read cycles
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      rdata <= 8'h00;
    else
      rdata <= rd_stb ? rd_mux : 8'h00;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_wdog_halt;
    @(posedge ref_clk) disable iff (!rstn)
      (stop_mode && !(pseudo_stop_sel && wdog_clk_sel && pseudo_stop_wdog_run)
       && !wr_stb && !wdog_fire) |=> $stable(wdog_count);
  endproperty
  a_wdog_halt: assert property (p_wdog_halt) else $error("watchdog ran in stop"); // see R02

  property p_wdog_service;
    @(posedge ref_clk) disable iff (!rstn)
      (svc_is_second && svc_state == wdog_tick_pkg::svc_armed && !svc_early)
      |=> (wdog_count == 24'h000000) && !wdog_reset;
  endproperty
  a_wdog_service: assert property (p_wdog_service) else $error("service no restart"); // see R04

  property p_wdog_expire;
    @(posedge ref_clk) disable iff (!rstn)
      (wdog_adv && wdog_lim != 24'h000000 && wdog_count == wdog_lim - 24'h000001
       && !wr_stb) |=> wdog_reset ##1 !wdog_reset;
  endproperty
  a_wdog_expire: assert property (p_wdog_expire) else $error("no timeout reset"); // see R05

  property p_bad_byte;
    @(posedge ref_clk) disable iff (!rstn)
      (wr_service && wdata != `SVC_FIRST && wdata != `SVC_SECOND) |=> wdog_reset;
  endproperty
  a_bad_byte: assert property (p_bad_byte) else $error("bad byte no reset"); // see R06

  property p_early_write;
    @(posedge ref_clk) disable iff (!rstn)
      (wr_service && windowed_wdog_en && wdog_period_sel != 3'h0
       && before_window(wdog_count, wdog_lim)) |=> wdog_reset;
  endproperty
  a_early_write: assert property (p_early_write) else $error("early write no reset"); // see R07

  property p_tick_flag;
    @(posedge ref_clk) disable iff (!rstn)
      tick_expire |=> flags[`BIT_FLAG_TICK] && tick_count == 24'h000000;
  endproperty
  a_tick_flag: assert property (p_tick_flag) else $error("tick flag missing"); // see R09

  property p_tick_restart;
    @(posedge ref_clk) disable iff (!rstn)
      wr_tick |=> tick_count == 24'h000000;
  endproperty
  a_tick_restart: assert property (p_tick_restart) else $error("tick not restarted"); // see R10

  property p_pll_flag;
    @(posedge ref_clk) disable iff (!rstn)
      (pll_settled != $past(pll_settled)) |=> ##1 flags[`BIT_FLAG_PLL];
  endproperty
  a_pll_flag: assert property (p_pll_flag) else $error("pll flag missing"); // see R11

  property p_osc_off;
    @(posedge ref_clk) disable iff (!rstn)
      (!ext_osc_enable || !pll_settled) |=> !osc_qualified_status;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("qualified while off"); // see R13 R15

  property p_lock;
    @(posedge ref_clk) disable iff (!rstn)
      (wdog_locked && wr_config) |=> $stable(wdog_period_sel) && $stable(windowed_wdog_en);
  endproperty
  a_lock: assert property (p_lock) else $error("locked field changed"); // see R17

  property p_irq;
    @(posedge ref_clk) disable iff (!rstn)
      ##1 (irq == $past(|(flags & irq_en)));
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch"); // see R12 R18

  c_service: cover property (@(posedge ref_clk) disable iff (!rstn) svc_done);
  c_timeout: cover property (@(posedge ref_clk) disable iff (!rstn) wdog_expire);
  c_tick: cover property (@(posedge ref_clk) disable iff (!rstn) tick_expire ##2 irq);
  c_osc: cover property (@(posedge ref_clk) disable iff (!rstn) flag_set[`BIT_FLAG_OSC]);

endmodule

//--- wdog_tick_status_tb.sv
// self-checking bench for the watchdog, tick and status interrupt block
// assumes the design files and wdog_tick_defs.svh are compiled alongside it
`timescale 1ns/1ps
`include "wdog_tick_defs.svh"
module wdog_tick_status_tb;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [7:0] rdata;
  logic internal_ref_clock = 1'b0;
  logic ext_osc_clock = 1'b0;
  logic stop_mode = 1'b0;
  logic normal_mode = 1'b0;
  logic full_performance_mode = 1'b0;
  logic pll_settled = 1'b0;
  logic osc_filter_ok = 1'b0;
  logic supply_low = 1'b0;
  logic wdog_reset;
  logic irq;
  logic [7:0] rst_seen = 8'h00;
  logic [7:0] exp_rst = 8'h00;
  int err_total = 0;
  int cmp_count = 0;
  int cycles = 0;

  // ----------------------------------------------------------------
  // clock, device, reset counter and hang guard
  // ----------------------------------------------------------------
  initial
  begin
    forever #4 ref_clk = ~ref_clk;
  end

  wdog_tick_status wdog_tick_status_inst (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .addr(addr),
    .wdata(wdata),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .rdata(rdata),
    .internal_ref_clock(internal_ref_clock),
    .ext_osc_clock(ext_osc_clock),
    .stop_mode(stop_mode),
    .normal_mode(normal_mode),
    .full_performance_mode(full_performance_mode),
    .pll_settled(pll_settled),
    .osc_filter_ok(osc_filter_ok),
    .supply_low(supply_low),
    .wdog_reset(wdog_reset),
    .irq(irq)
  );

  // count watchdog reset pulses, cut a hang short
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (wdog_reset === 1'b1)
      rst_seen <= rst_seen + 8'h01;
    if (cycles == 60000)
    begin
      err_total++;
      $display("MISMATCH run length expected below 60000 seen 60000");
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // bus, tick and compare tasks
  // ----------------------------------------------------------------
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic clk_n(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic do_reset();
    @(posedge ref_clk);
    rstn <= 1'b0;
    stop_mode <= 1'b0;
    normal_mode <= 1'b0;
    full_performance_mode <= 1'b0;
    pll_settled <= 1'b0;
    supply_low <= 1'b0;
    osc_filter_ok <= 1'b0;
    clk_n(20);
    rstn <= 1'b1;
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    @(posedge ref_clk); // read data stood since the last edge
    chk8(what, exp, rdata);
  endtask

  // alternate high and low so every tick is a clean one-cycle pulse
  task automatic ticks(input int n, input logic ext);
    repeat (n)
    begin
      @(posedge ref_clk);
      internal_ref_clock <= ~ext;
      ext_osc_clock <= ext;
      @(posedge ref_clk);
      internal_ref_clock <= 1'b0;
      ext_osc_clock <= 1'b0;
    end
  endtask

  task automatic irq_is(input logic exp);
    clk_n(4);
    chk8("irq", {7'h00, exp}, {7'h00, irq});
  endtask

  task automatic rst_chk();
    clk_n(4);
    chk8("wdog resets", exp_rst, rst_seen);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values();
    for (int a = 0; a < 9; a++)
      rd_chk(a[7:0], 8'h00, "reset value");
    $display("test reset values done");
  endtask

  task automatic t_service();
    do_reset();
    ticks(1100, 1'b0);
    rst_chk();
    bus_wr(`OFS_WDOG_CONFIG, 8'h02);
    ticks(1100, 1'b0);
    rst_chk();
    bus_wr(`OFS_WDOG_CONFIG, 8'h01);
    ticks(1000, 1'b0);
    bus_wr(`OFS_WDOG_SERVICE, `SVC_FIRST);
    bus_wr(`OFS_WDOG_SERVICE, `SVC_SECOND);
    ticks(1000, 1'b0);
    rst_chk();
    ticks(30, 1'b0);
    exp_rst++;
    rst_chk();
    bus_wr(`OFS_WDOG_SERVICE, `SVC_SECOND);
    rst_chk();
    bus_wr(`OFS_WDOG_SERVICE, 8'h12);
    exp_rst++;
    rst_chk();
    $display("test service done");
  endtask

  task automatic t_window();
    do_reset();
    bus_wr(`OFS_WDOG_CONFIG, 8'h81);
    ticks(100, 1'b0);
    bus_wr(`OFS_WDOG_SERVICE, `SVC_FIRST);
    exp_rst++;
    rst_chk();
    ticks(800, 1'b0);
    bus_wr(`OFS_WDOG_SERVICE, `SVC_FIRST);
    bus_wr(`OFS_WDOG_SERVICE, `SVC_SECOND);
    ticks(1000, 1'b0);
    rst_chk();
    $display("test window done");
  endtask

  task automatic t_clk_source();
    do_reset();
    bus_wr(`OFS_WDOG_CONFIG, 8'h41);
    ticks(1100, 1'b0);
    rst_chk();
    ticks(1030, 1'b1);
    exp_rst++;
    rst_chk();
    bus_wr(`OFS_CLK_CTRL, 8'h04);
    stop_mode <= 1'b1;
    bus_wr(`OFS_WDOG_CONFIG, 8'h61);
    ticks(1030, 1'b1);
    exp_rst++;
    rst_chk();
    bus_wr(`OFS_CLK_CTRL, 8'h00);
    bus_wr(`OFS_WDOG_CONFIG, 8'h61);
    ticks(1100, 1'b1);
    rst_chk();
    stop_mode <= 1'b0;
    $display("test clock source done");
  endtask

  task automatic t_tick();
    do_reset();
    bus_wr(`OFS_IRQ_MASK, 8'h01);
    bus_wr(`OFS_TICK_PERIOD, 8'h01);
    ticks(15, 1'b0);
    irq_is(1'b0);
    ticks(1, 1'b0);
    irq_is(1'b1);
    rd_chk(`OFS_IRQ_STATUS, 8'h01, "tick flag");
    irq_is(1'b0);
    ticks(10, 1'b0);
    bus_wr(`OFS_TICK_PERIOD, 8'h01);
    ticks(10, 1'b0);
    irq_is(1'b0);
    ticks(6, 1'b0);
    irq_is(1'b1);
    rd_chk(`OFS_IRQ_STATUS, 8'h01, "tick flag again");
    bus_wr(`OFS_CLK_CTRL, 8'h07);
    stop_mode <= 1'b1;
    bus_wr(`OFS_TICK_PERIOD, 8'h01);
    ticks(16, 1'b0);
    irq_is(1'b0);
    ticks(16, 1'b1);
    irq_is(1'b1);
    rd_chk(`OFS_IRQ_STATUS, 8'h01, "tick flag pseudo stop");
    bus_wr(`OFS_CLK_CTRL, 8'h01);
    bus_wr(`OFS_TICK_PERIOD, 8'h01);
    ticks(20, 1'b1);
    irq_is(1'b0);
    $display("test tick done");
  endtask

  task automatic t_pll_osc();
    do_reset();
    pll_settled <= 1'b1;
    irq_is(1'b0);
    rd_chk(`OFS_STATUS, 8'h01, "status osc off");
    rd_chk(`OFS_IRQ_STATUS, 8'h02, "pll flag");
    pll_settled <= 1'b0;
    clk_n(4);
    bus_wr(`OFS_IRQ_STATUS, 8'h02);
    rd_chk(`OFS_IRQ_STATUS, 8'h00, "pll flag cleared");
    pll_settled <= 1'b1;
    bus_wr(`OFS_CLK_CTRL, 8'h08);
    clk_n(4);
    rd_chk(`OFS_STATUS, 8'h03, "status qualified");
    rd_chk(`OFS_IRQ_STATUS, 8'h06, "pll and osc flags");
    bus_wr(`OFS_IRQ_MASK, 8'h04);
    pll_settled <= 1'b0;
    irq_is(1'b1);
    rd_chk(`OFS_STATUS, 8'h00, "status pll lost");
    rd_chk(`OFS_IRQ_STATUS, 8'h06, "flags after loss");
    irq_is(1'b0);
    bus_wr(`OFS_OSC_FILTER, 8'h01);
    pll_settled <= 1'b1;
    clk_n(4);
    rd_chk(`OFS_STATUS, 8'h01, "filter not yet ok");
    osc_filter_ok <= 1'b1;
    irq_is(1'b1);
    rd_chk(`OFS_STATUS, 8'h03, "filter qualified");
    $display("test pll and oscillator done");
  endtask

  task automatic t_low_voltage();
    do_reset();
    full_performance_mode <= 1'b1;
    supply_low <= 1'b1;
    clk_n(4);
    rd_chk(`OFS_STATUS, 8'h04, "low voltage status");
    bus_wr(`OFS_IRQ_MASK, 8'h08);
    irq_is(1'b1);
    rd_chk(`OFS_IRQ_STATUS, 8'h08, "low voltage flag");
    full_performance_mode <= 1'b0;
    supply_low <= 1'b0;
    clk_n(4);
    rd_chk(`OFS_STATUS, 8'h04, "low voltage held");
    $display("test low voltage done");
  endtask

  task automatic t_lock();
    do_reset();
    bus_wr(`OFS_WDOG_CONFIG, 8'h02);
    bus_wr(`OFS_WDOG_CONFIG, 8'h01);
    rd_chk(`OFS_WDOG_CONFIG, 8'h01, "config unlocked");
    normal_mode <= 1'b1;
    bus_wr(`OFS_WDOG_CONFIG, 8'h01);
    bus_wr(`OFS_WDOG_CONFIG, 8'hE6);
    rd_chk(`OFS_WDOG_CONFIG, 8'h61, "config locked");
    rd_chk(`OFS_STATUS, 8'h08, "lock status");
    $display("test lock done");
  endtask

  // ----------------------------------------------------------------
  // verdict and main sequence
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    do_reset();
    t_reset_values();
    t_service();
    t_window();
    t_clk_source();
    t_tick();
    t_pll_osc();
    t_low_voltage();
    t_lock();
    summarize();
  end
endmodule
